// ---- rtl/tcp_pkg.sv ----
// shared constants and types for the timer compare/pwm channel block
`default_nettype none
package tcp_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned IDX_W = 10;
    localparam int unsigned PRE_W = 6;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h040;
    localparam logic [IDX_W-1:0] IDX_CNT_HI = 10'h041;
    localparam logic [IDX_W-1:0] IDX_CNT_LO = 10'h042;
    localparam logic [IDX_W-1:0] IDX_MOD_HI = 10'h043;
    localparam logic [IDX_W-1:0] IDX_MOD_LO = 10'h044;
    localparam logic [IDX_W-1:0] IDX_CH0_SC = 10'h045;
    localparam logic [IDX_W-1:0] IDX_CH0_HI = 10'h046;
    localparam logic [IDX_W-1:0] IDX_CH0_LO = 10'h047;
    localparam logic [IDX_W-1:0] IDX_CH1_SC = 10'h048;
    localparam logic [IDX_W-1:0] IDX_CH1_HI = 10'h049;
    localparam logic [IDX_W-1:0] IDX_CH1_LO = 10'h04A;

    // timer_status_control layout
    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic counter_halt;
        logic counter_reset;
        logic reserved;
        logic [2:0] prescale_sel;
    } tcp_status_t;

    // channel status/control layout
    typedef struct packed {
        logic channel_event_flag;
        logic channel_irq_enable;
        logic mode_sel_high;
        logic mode_sel_low;
        logic edge_level_sel_high;
        logic edge_level_sel_low;
        logic toggle_on_overflow;
        logic max_duty_force;
    } tcp_chan_ctrl_t;

    localparam tcp_status_t STATUS_RESET = 8'h20;
    localparam tcp_chan_ctrl_t CHAN_CTRL_RESET = 8'h00;
    localparam logic [CNT_W-1:0] MODULO_RESET = 16'hFFFF;
    localparam logic [2:0] PRESCALE_EXT = 3'h7;

    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_UNBUFFERED = 2'h1;
    localparam logic [1:0] MODE_BUFFERED = 2'h2;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
endpackage : tcp_pkg
`default_nettype wire

// ---- rtl/tcp_timer_pwm.sv ----
// two-channel output-compare / pwm timer with apb register access
`default_nettype none

// Overview of operation
// - compare value registers are never cleared or loaded by reset.
// - counter equal to compare value sets, clears or toggles the channel pin.
// - an output compare match can raise the interrupt when enabled.
// - unbuffered writes replace the active compare value immediately.
// - channel interrupt at compare match, overflow interrupt at period end.
// - link bit on channel 0 joins both channels, output on channel 0 pin.
// - linked mode starts on channel 0 pair; channel 1 takes over after written.
// - at each overflow the most recently written pair controls the output.
// - while linked, channel 1 control ignored and its pin released.
// - toggle-on-overflow toggles the pin when counter reaches modulo.
// - pwm period is modulo plus one counter clocks.
// - pulse width is time from overflow to compare match for the clear action, match to overflow for set.
// - mode field 01 means unbuffered, 10 means buffered.
// - edge/level field 10 clears, 11 sets the pin on compare.
// - link bit wins over the unbuffered mode bit on channel 0.
// - without toggle-on-overflow, pin never toggles at overflow; duty 0 percent with the clear action.
// - max duty bit plus toggle-on-overflow gives 100 percent duty.
// - a passed compare value produces no match in that period.
// - overflow flag set on reaching modulo; overflow interrupt enable gates interrupt.
// - channel event flag set on compare; channel enable gates interrupt.
// - one 16-bit up-counter, free running or modulo, times all channels.
module tcp_timer_pwm (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcp_pkg::ADDR_W-1:0] paddr,
    input wire logic [tcp_pkg::DATA_W-1:0] pwdata,
    output logic [tcp_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clk_pin,
    output logic channel0_pin_out,
    output logic channel0_pin_oe_n,
    output logic channel1_pin_out,
    output logic channel1_pin_oe_n,
    output logic timer_irq
);
    import tcp_pkg::*;

    function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
        return idx >= IDX_STATUS && idx <= IDX_CH1_LO;
    endfunction : is_mapped

    function automatic logic [PRE_W-1:0] prescale_mask(input logic [2:0] sel);
        logic [PRE_W:0] one_hot;
        one_hot = 7'h01 << sel;
        return PRE_W'(one_hot - 7'h01);
    endfunction : prescale_mask

    // toggle on overflow first, then the compare action, max duty overrides only when toggle-on-overflow is also set
    function automatic logic pin_next(input logic cur, input tcp_chan_ctrl_t cfg,
                                      input logic wrap, input logic match);
        logic lvl;
        lvl = cur;
        if (wrap && cfg.toggle_on_overflow) begin
            lvl = ~lvl;
        end
        if (match) begin
            case ({cfg.edge_level_sel_high, cfg.edge_level_sel_low})
                ELS_TOGGLE: lvl = ~lvl;
                ELS_CLEAR: lvl = 1'b0;
                ELS_SET: lvl = 1'b1;
                default: lvl = lvl;
            endcase
        end
        if (cfg.max_duty_force && cfg.toggle_on_overflow) begin
            lvl = 1'b1;
        end
        return lvl;
    endfunction : pin_next

    // register state
    logic overflow_flag;
    logic overflow_irq_enable;
    logic counter_halt;
    logic [2:0] prescale_sel;
    logic [CNT_W-1:0] counter_modulo_value;
    tcp_chan_ctrl_t chan_ctrl [2];
    logic [CNT_W-1:0] channel_compare_value [2];
    logic [1:0] channel_event_flag;
    logic overflow_armed;
    logic [1:0] chan_armed;
    logic active_pair;
    logic last_written;

    // counter state
    logic [CNT_W-1:0] count;
    logic [PRE_W-1:0] prescale_count;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic [1:0] pin_level;

    // bus decode
    logic [IDX_W-1:0] idx;
    logic aligned;
    logic bus_write;
    logic bus_read_done;
    logic [7:0] wbyte;
    logic [7:0] read_byte;

    assign idx = paddr[ADDR_W-1:2];
    assign aligned = paddr[1:0] == 2'h0;
    assign bus_write = psel && penable && pready && pwrite && aligned;
    assign bus_read_done = psel && penable && pready && !pwrite && aligned;
    assign wbyte = pwdata[7:0];

    // timebase
    logic link;
    logic cnt_clear;
    logic tick;
    logic wrap_evt;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] eff_compare [2];
    logic [1:0] oc_on;
    logic [1:0] drive;
    logic [1:0] match_evt;

    assign link = chan_ctrl[0].mode_sel_high;
    assign cnt_clear = bus_write && idx == IDX_STATUS && wbyte[4];
    assign tick = !counter_halt && !cnt_clear &&
        (prescale_sel == PRESCALE_EXT ? (ext_sync2 && !ext_prev)
                                      : (prescale_count & prescale_mask(prescale_sel)) == prescale_mask(prescale_sel));
    assign wrap_evt = tick && count == counter_modulo_value;
    assign next_count = wrap_evt ? '0 : CNT_W'(count + 16'h0001);

    // linked pair picks its compare value from the active pair
    assign eff_compare[0] = link ? channel_compare_value[active_pair] : channel_compare_value[0];
    assign eff_compare[1] = channel_compare_value[1];
    assign oc_on[0] = chan_ctrl[0].mode_sel_high || chan_ctrl[0].mode_sel_low;
    assign oc_on[1] = !link && chan_ctrl[1].mode_sel_low;
    assign drive[0] = oc_on[0] && (chan_ctrl[0].edge_level_sel_high || chan_ctrl[0].edge_level_sel_low);
    assign drive[1] = oc_on[1] && (chan_ctrl[1].edge_level_sel_high || chan_ctrl[1].edge_level_sel_low);
    // equality only: a value the counter already passed waits a whole period
    assign match_evt[0] = tick && oc_on[0] && next_count == eff_compare[0];
    assign match_evt[1] = tick && oc_on[1] && next_count == eff_compare[1];

    // external clock pin, two flops before the edge detector
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_sync1 <= ext_clk_pin;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || cnt_clear) begin
            prescale_count <= '0;
        end else if (!counter_halt) begin
            prescale_count <= PRE_W'(prescale_count + 6'h01);
        end
    end

    always_ff @(posedge clk) begin
        if (reset || cnt_clear) begin
            count <= '0;
        end else if (tick) begin
            count <= next_count;
        end
    end

    // status/control register
    always_ff @(posedge clk) begin
        if (reset) begin
            overflow_irq_enable <= STATUS_RESET.overflow_irq_enable;
            counter_halt <= STATUS_RESET.counter_halt;
            prescale_sel <= STATUS_RESET.prescale_sel;
        end else if (bus_write && idx == IDX_STATUS) begin
            overflow_irq_enable <= wbyte[6];
            counter_halt <= wbyte[5];
            prescale_sel <= wbyte[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            counter_modulo_value <= MODULO_RESET;
        end else if (bus_write && idx == IDX_MOD_HI) begin
            counter_modulo_value[15:8] <= wbyte;
        end else if (bus_write && idx == IDX_MOD_LO) begin
            counter_modulo_value[7:0] <= wbyte;
        end
    end

    // channel controls; channel 1 control is dead while linked
    always_ff @(posedge clk) begin
        if (reset) begin
            chan_ctrl[0] <= CHAN_CTRL_RESET;
            chan_ctrl[1] <= CHAN_CTRL_RESET;
        end else begin
            if (bus_write && idx == IDX_CH0_SC) begin
                chan_ctrl[0] <= {1'b0, wbyte[6:0]};
            end
            if (bus_write && idx == IDX_CH1_SC && !link) begin
                chan_ctrl[1] <= {2'b00, 1'b0, wbyte[4:0]} | {1'b0, wbyte[6], 6'h00};
            end
        end
    end

    // compare values are not touched by reset
    always_ff @(posedge clk) begin
        if (bus_write && idx == IDX_CH0_HI) begin
            channel_compare_value[0][15:8] <= wbyte;
        end
        if (bus_write && idx == IDX_CH0_LO) begin
            channel_compare_value[0][7:0] <= wbyte;
        end
        if (bus_write && idx == IDX_CH1_HI) begin
            channel_compare_value[1][15:8] <= wbyte;
        end
        if (bus_write && idx == IDX_CH1_LO) begin
            channel_compare_value[1][7:0] <= wbyte;
        end
    end

    // pair bookkeeping for linked mode
    always_ff @(posedge clk) begin
        if (reset || !link) begin
            last_written <= 1'b0;
            active_pair <= 1'b0;
        end else begin
            if (bus_write && (idx == IDX_CH0_HI || idx == IDX_CH0_LO)) begin
                last_written <= 1'b0;
            end else if (bus_write && (idx == IDX_CH1_HI || idx == IDX_CH1_LO)) begin
                last_written <= 1'b1;
            end
            if (wrap_evt) begin
                active_pair <= last_written;
            end
        end
    end

    // overflow flag: read while set, then write 0; a new overflow wins
    always_ff @(posedge clk) begin
        if (reset) begin
            overflow_flag <= 1'b0;
            overflow_armed <= 1'b0;
        end else if (wrap_evt) begin
            overflow_flag <= 1'b1;
            overflow_armed <= 1'b0;
        end else if (bus_write && idx == IDX_STATUS && !wbyte[7] && overflow_armed) begin
            overflow_flag <= 1'b0;
            overflow_armed <= 1'b0;
        end else if (bus_read_done && idx == IDX_STATUS && overflow_flag) begin
            overflow_armed <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            channel_event_flag <= 2'h0;
            chan_armed <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (match_evt[c]) begin
                    channel_event_flag[c] <= 1'b1;
                    chan_armed[c] <= 1'b0;
                end else if (bus_write && idx == (c == 0 ? IDX_CH0_SC : IDX_CH1_SC)
                             && !wbyte[7] && chan_armed[c]) begin
                    channel_event_flag[c] <= 1'b0;
                    chan_armed[c] <= 1'b0;
                end else if (bus_read_done && idx == (c == 0 ? IDX_CH0_SC : IDX_CH1_SC)
                             && channel_event_flag[c]) begin
                    chan_armed[c] <= 1'b1;
                end
            end
        end
    end

    // pin levels; released pins keep tracking so re-enabling is glitch free, channel 1 only while its output compare is on
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_level <= 2'h0;
        end else begin
            pin_level[0] <= pin_next(pin_level[0], chan_ctrl[0], wrap_evt, match_evt[0]);
            pin_level[1] <= pin_next(pin_level[1], chan_ctrl[1], wrap_evt && oc_on[1], match_evt[1]);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            channel0_pin_out <= 1'b0;
            channel1_pin_out <= 1'b0;
            channel0_pin_oe_n <= 1'b1;
            channel1_pin_oe_n <= 1'b1;
        end else begin
            channel0_pin_out <= pin_next(pin_level[0], chan_ctrl[0], wrap_evt, match_evt[0]);
            channel1_pin_out <= pin_next(pin_level[1], chan_ctrl[1], wrap_evt && oc_on[1], match_evt[1]);
            channel0_pin_oe_n <= !drive[0];
            channel1_pin_oe_n <= !drive[1];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= (overflow_flag && overflow_irq_enable) ||
                (channel_event_flag[0] && chan_ctrl[0].channel_irq_enable) ||
                (channel_event_flag[1] && chan_ctrl[1].channel_irq_enable && !link);
        end
    end

    // read mux
    always_comb begin
        read_byte = 8'h00;
        unique case (idx)
            IDX_STATUS: read_byte = {overflow_flag, overflow_irq_enable, counter_halt, 2'b00, prescale_sel};
            IDX_CNT_HI: read_byte = count[15:8];
            IDX_CNT_LO: read_byte = count[7:0];
            IDX_MOD_HI: read_byte = counter_modulo_value[15:8];
            IDX_MOD_LO: read_byte = counter_modulo_value[7:0];
            IDX_CH0_SC: read_byte = {channel_event_flag[0], chan_ctrl[0][6:0]};
            IDX_CH0_HI: read_byte = channel_compare_value[0][15:8];
            IDX_CH0_LO: read_byte = channel_compare_value[0][7:0];
            IDX_CH1_SC: read_byte = {channel_event_flag[1], chan_ctrl[1][6:0]};
            IDX_CH1_HI: read_byte = channel_compare_value[1][15:8];
            IDX_CH1_LO: read_byte = channel_compare_value[1][7:0];
            default: read_byte = 8'h00;
        endcase
    end

    // apb slave: no wait states, data captured in the setup cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !(aligned && is_mapped(idx));
            if (psel && !penable) begin
                prdata <= (!pwrite && aligned && is_mapped(idx)) ? {24'h00_0000, read_byte} : 32'h0000_0000;
            end
        end
    end

    pin_set_a: assert property (@(posedge clk) disable iff (reset)
        match_evt[0] && chan_ctrl[0][3:2] == ELS_SET |=> channel0_pin_out)
        else $error("set action did not raise channel 0 pin");

    pin_clear_a: assert property (@(posedge clk) disable iff (reset)
        match_evt[0] && chan_ctrl[0][3:2] == ELS_CLEAR && !chan_ctrl[0].max_duty_force |=> !channel0_pin_out)
        else $error("clear action did not lower channel 0 pin");

    wrap_zero_a: assert property (@(posedge clk) disable iff (reset)
        wrap_evt |=> count == 16'h0000)
        else $error("counter did not return to zero after modulo");

    ovf_flag_a: assert property (@(posedge clk) disable iff (reset)
        wrap_evt |=> overflow_flag ##1 (overflow_flag || $past(bus_write)))
        else $error("overflow flag not set at modulo");

    chan_flag_a: assert property (@(posedge clk) disable iff (reset)
        match_evt[0] |=> channel_event_flag[0])
        else $error("channel 0 event flag not set on compare");

    pair_swap_a: assert property (@(posedge clk) disable iff (reset)
        wrap_evt && link ##1 link |-> active_pair == $past(last_written))
        else $error("linked pair did not follow last written pair");

    ch1_release_a: assert property (@(posedge clk) disable iff (reset)
        link [*2] |-> channel1_pin_oe_n)
        else $error("channel 1 pin driven while linked");

    ovf_toggle_a: assert property (@(posedge clk) disable iff (reset)
        wrap_evt && chan_ctrl[0].toggle_on_overflow && !match_evt[0] && !chan_ctrl[0].max_duty_force
        |=> channel0_pin_out != $past(channel0_pin_out))
        else $error("channel 0 pin did not toggle on overflow");

    no_toggle_a: assert property (@(posedge clk) disable iff (reset)
        wrap_evt && !chan_ctrl[0].toggle_on_overflow && !match_evt[0] |=> $stable(channel0_pin_out))
        else $error("channel 0 pin toggled with toggle-on-overflow clear");

    max_duty_a: assert property (@(posedge clk) disable iff (reset)
        chan_ctrl[0].max_duty_force && chan_ctrl[0].toggle_on_overflow |=> channel0_pin_out)
        else $error("max duty did not hold channel 0 pin high");

    irq_a: assert property (@(posedge clk) disable iff (reset)
        match_evt[0] && chan_ctrl[0].channel_irq_enable ##1 chan_ctrl[0].channel_irq_enable |=> timer_irq)
        else $error("compare match did not raise the interrupt");

    unbuf_write_a: assert property (@(posedge clk) disable iff (reset)
        bus_write && idx == IDX_CH0_LO |=> channel_compare_value[0][7:0] == $past(wbyte))
        else $error("compare write did not take effect at once");
endmodule : tcp_timer_pwm
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the timer compare/pwm block
`default_nettype none
module tb_top;
    import tcp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0000_0000;
    logic ext_clk_pin = 1'b0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, ch0_out, ch0_oe_n, ch1_out, ch1_oe_n, timer_irq, lvl0;
    logic [15:0] per0, high0;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    tcp_timer_pwm dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk_pin(ext_clk_pin), .channel0_pin_out(ch0_out), .channel0_pin_oe_n(ch0_oe_n),
        .channel1_pin_out(ch1_out), .channel1_pin_oe_n(ch1_oe_n), .timer_irq(timer_irq));
    tcp_pin_load load0 (.clk(clk), .reset(reset), .pin_out(ch0_out), .pin_oe_n(ch0_oe_n),
        .level(lvl0), .last_period(per0), .last_high(high0));

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: pin cycles %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] idx);
        return {idx, 2'b00};
    endfunction : ba

    // set-on-compare pulses run from match to overflow, clear-on-compare the other way
    function automatic logic [15:0] exp_high(input int m, input int c, input int ps, input logic set_act);
        return 16'((set_act ? m + 1 - c : c) << ps);
    endfunction : exp_high

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd,
                       output logic [DATA_W-1:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        // no local limit: only the bench timeout ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk_val({31'h0000_0000, pready}, 32'h0000_0001);
    endtask : apb

    task automatic reg_wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
        logic [DATA_W-1:0] d;
        logic e;
        apb(1'b1, ba(idx), v, d, e);
    endtask : reg_wr

    task automatic reg_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
        logic [DATA_W-1:0] d;
        logic e;
        apb(1'b0, ba(idx), 8'h00, d, e);
        chk_val(d, {24'h00_0000, exp});
    endtask : reg_chk

    // halt and clear the counter before reprogramming so the first period is whole
    task automatic pwm_setup(input int m, input int c, input int ps, input logic [7:0] sc);
        reg_wr(IDX_STATUS, 8'h30);
        reg_wr(IDX_MOD_HI, 8'(m >> 8));
        reg_wr(IDX_MOD_LO, 8'(m));
        reg_wr(IDX_CH0_HI, 8'(c >> 8));
        reg_wr(IDX_CH0_LO, 8'(c));
        reg_wr(IDX_CH0_SC, sc);
        reg_wr(IDX_STATUS, 8'(ps));
    endtask : pwm_setup

    initial begin
        logic [DATA_W-1:0] d;
        logic e;
        int m, c, ps, h, h1;
        logic [7:0] sc;
        void'($urandom(32'h3303));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        reg_chk(IDX_STATUS, 8'h20);
        reg_chk(IDX_MOD_HI, 8'hFF);
        reg_chk(IDX_MOD_LO, 8'hFF);
        reg_chk(IDX_CH0_SC, 8'h00);
        chk_val({30'h0000_0000, ch0_oe_n, ch1_oe_n}, 32'h0000_0003);
        apb(1'b0, 12'h000, 8'h00, d, e);
        chk_val({e, d[30:0]}, 32'h8000_0000);
        reg_wr(IDX_CH0_HI, 8'h12);
        reg_wr(IDX_CH0_LO, 8'h34);
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        reg_chk(IDX_CH0_HI, 8'h12);
        reg_chk(IDX_CH0_LO, 8'h34);
        // first pass is the corner where the match lands on the modulo value
        for (int i = 0; i < 8; i++) begin
            m = 8 + int'($urandom_range(32));
            c = (i == 0) ? m : 1 + int'($urandom_range(m - 1));
            ps = int'($urandom_range(2));
            sc = (i % 2 == 1) ? 8'h5E : 8'h1A;
            pwm_setup(m, c, ps, sc);
            // four periods: a set action entering high needs one extra period to settle
            repeat (4 * ((m + 1) << ps)) @(posedge clk);
            chk_cnt(per0, 16'((m + 1) << ps));
            chk_cnt(high0, exp_high(m, c, ps, sc[2]));
            reg_chk(IDX_CH0_SC, sc | 8'h80);
            chk_val({31'h0000_0000, timer_irq}, {31'h0000_0000, sc[6]});
        end
        c = 1 + int'($urandom_range(m - 1));
        reg_wr(IDX_CH0_LO, 8'(c));
        repeat (4 * ((m + 1) << ps)) @(posedge clk);
        chk_cnt(high0, exp_high(m, c, ps, sc[2]));
        for (int j = 0; j < 2; j++) begin
            sc = (j == 1) ? 8'h1B : 8'h18;
            pwm_setup(15, 6, 0, sc);
            reg_wr(IDX_CH1_HI, 8'h00);
            reg_wr(IDX_CH1_LO, 8'h06);
            reg_wr(IDX_CH1_SC, sc);
            repeat (32) @(posedge clk);
            h = 0;
            h1 = 0;
            repeat (48) begin
                @(posedge clk);
                h += (lvl0 === 1'b1) ? 1 : 0;
                // channel 1 must drive, low for 0 percent, high for 100 percent
                h1 += ({ch1_oe_n, ch1_out} === {1'b0, sc[0]}) ? 1 : 0;
            end
            chk_cnt(16'(h), (j == 1) ? 16'h0030 : 16'h0000);
            chk_cnt(16'(h1), 16'h0030);
        end
        reg_wr(IDX_STATUS, 8'h40);
        h = 0;
        while (timer_irq !== 1'b1 && h < 40) begin
            @(posedge clk);
            h++;
        end
        chk_val({31'h0000_0000, timer_irq}, 32'h0000_0001);
        // halt first so no fresh overflow races the two-step flag clear
        reg_wr(IDX_STATUS, 8'hE0);
        reg_chk(IDX_STATUS, 8'hE0);
        reg_wr(IDX_STATUS, 8'h60);
        repeat (2) @(posedge clk);
        chk_val({31'h0000_0000, timer_irq}, 32'h0000_0000);
        pwm_setup(31, 8, 0, 8'h3A);
        repeat (96) @(posedge clk);
        chk_cnt(high0, 16'h0008);
        chk_val({31'h0000_0000, ch1_oe_n}, 32'h0000_0001);
        reg_wr(IDX_CH1_HI, 8'h00);
        reg_wr(IDX_CH1_LO, 8'h14);
        repeat (96) @(posedge clk);
        chk_cnt(high0, 16'h0014);
        reg_wr(IDX_CH0_LO, 8'h0C);
        repeat (96) @(posedge clk);
        chk_cnt(high0, 16'h000C);
        reg_wr(IDX_CH1_SC, 8'h1A);
        reg_chk(IDX_CH1_SC, 8'h9B);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// ---- tb/tcp_pin_load.sv ----
// load model on a channel pin: resolves the wire level and times its pulses
`default_nettype none
module tcp_pin_load (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic level,
    output logic [15:0] last_period,
    output logic [15:0] last_high
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev;
    logic [15:0] since;
    logic [15:0] high_run;
    // a released pin falls to the load's pull-down, never keeps the old level
    assign level = pin_oe_n ? 1'b0 : pin_out;
    always_ff @(posedge clk) begin
        prev <= level;
        if (reset) begin
            since <= 16'h0000;
            high_run <= 16'h0000;
            last_period <= 16'h0000;
            last_high <= 16'h0000;
        end else if (level && !prev) begin
            last_period <= since;
            last_high <= high_run;
            since <= 16'h0001;
            high_run <= 16'h0001;
        end else begin
            since <= since + 16'h0001;
            high_run <= high_run + {15'h0000, level};
        end
    end
endmodule : tcp_pin_load
`default_nettype wire
